/* logic/cbt_consts.svh */
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH
// Register byte addresses
`define CBT_ADDR_CTRL   8'h00
`define CBT_ADDR_ALERT  8'h04
`define CBT_ADDR_BAL    8'h08
`define CBT_ADDR_CBT0   8'h0C
`define CBT_ADDR_CBT5   8'h20
`define CBT_ADDR_PDT    8'h24
`define CBT_ADDR_STAT   8'h28
// Reset values and writable masks
`define CBT_CTRL_RST    16'h0000
`define CBT_CTRL_MASK   16'hF768
`define CBT_ALERT_RST   8'h00
`define CBT_BAL_RST     6'h00
`define CBT_TMR_RST     5'h00
// Control field positions
`define CBT_CONV_HI     15
`define CBT_CONV_LO     14
`define CBT_RDB_HI      13
`define CBT_RDB_LO      12
`define CBT_AVG_HI      10
`define CBT_AVG_LO      9
`define CBT_SWPD_BIT    8
`define CBT_ACQ_HI      6
`define CBT_ACQ_LO      5
`define CBT_TERM_BIT    3
// Alert temperature exclusion field
`define CBT_TEXC_HI     1
`define CBT_TEXC_LO     0
// Channel masks
`define CBT_TEMP_ALL    6'h3F
`define CBT_TEMP_ODD    6'h15
`define CBT_TEMP_NONE   6'h00
`define CBT_TFLT_NO5    6'h2F
`define CBT_TFLT_NO53   6'h2B
// Timer limits
`define CBT_CBT_MAX     5'h1E
// Timing
`define CBT_CLK_NS      10
`define CBT_ACQ_STEP_NS 400
`define CBT_MINUTE_S    60
`define CBT_NS_PER_S    1000000000
// AXI responses
`define CBT_RESP_OK     2'h0
`define CBT_RESP_ERR    2'h2
`endif

/* logic/cbt_pkg.sv */
package cbt_pkg;
	// Power sequencing states, one-hot
	typedef enum logic [3:0] {
		CBT_RUN  = 4'h1,
		CBT_WAIT = 4'h2,
		CBT_HWPD = 4'h4,
		CBT_SWPD = 4'h8
	} cbt_state_e;

	// Conversion configuration handed to the converter
	typedef struct packed {
		logic [1:0] conv_sel;
		logic [1:0] readback_sel;
		logic [1:0] avg_sel;
		logic [1:0] acq_sel;
		logic       term_en;
	} cbt_cfg_s;
endpackage

/* logic/cbt_bal_timer.sv */
`timescale 1ns/100ps
`include "cbt_consts.svh"
// One balance on-time countdown in minutes
module cbt_bal_timer (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic [4:0] limit,
	input  wire logic       tick,
	output logic            expire,
	output logic [4:0]      remain
);
	logic [4:0] cnt_r; // Minutes left, zero means idle

	// Load on switch-on, count down on each minute tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= `CBT_TMR_RST;
		end else if (start) begin
			cnt_r <= limit;
		end else if (tick && cnt_r != `CBT_TMR_RST) begin
			cnt_r <= cnt_r - 5'h01;
		end
	end

	// Last minute ends: output returns off
	assign expire = tick && !start && cnt_r == 5'h01;
	assign remain = cnt_r;
endmodule

/* logic/cbt_top.sv */
`timescale 1ns/100ps
`include "cbt_consts.svh"
// Contract
// - Control bits 15:14 choose temperature conversions
// - Conversion select: all, odd three, none, selftest
// - Control bits 13:12 choose readback count
// - Alert bits 1:0 exclude temperatures from faults
// - Exclusion: none, fifth, fifth and third
// - Bits 6:5 give acquisition 400ns steps
// - Shutdown pin fall starts full power-down
// - Bit 8 set starts software power-down
// - Shutdown delay 0 to 31 minutes
// - Request while running starts delay, then powers down; pin fall in software power-down goes straight to full power-down
// - Shutdown delay register resets to zero
// - Six balance outputs from balance register
// - Balance register resets to zero
// - Six balance timers, 0 to 30 minutes
// - Timer expiry switches balance output off
// - Balance timer registers reset to zero
// - Zero delay: immediate off and power-down
// - Nonzero delay: balancing continues until expiry
module cbt_top #(
	parameter logic [32:0] MIN_CYC = 33'(64'(`CBT_MINUTE_S)
		* 64'(`CBT_NS_PER_S) / 64'(`CBT_CLK_NS))
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              shutdown_n_pin,
	output logic [5:0]             cell_balance_output,
	output cbt_pkg::cbt_cfg_s      cfg,
	output logic [5:0]             temp_conv_en,
	output logic [5:0]             temp_fault_en,
	output logic                   self_test_mode,
	output logic [7:0]             acq_cycles,
	output logic                   full_pd,
	output logic                   soft_pd,
	output logic                   core_power_en,
	output logic                   link_power_en
);
	import cbt_pkg::*;

	// Acquisition step in clock cycles
	localparam logic [7:0] ACQ_STEP =
		8'(`CBT_ACQ_STEP_NS / `CBT_CLK_NS);

	// Bus write holding
	logic        aw_hold_r;   // Address taken, waiting for data
	logic [7:0]  aw_addr_r;   // Held write address
	logic        w_hold_r;    // Data taken, waiting for address
	logic [31:0] w_data_r;    // Held write data
	logic [3:0]  w_strb_r;    // Held byte enables
	logic        bvalid_r;    // Write response pending
	logic [1:0]  bresp_r;     // Write response code
	logic        rvalid_r;    // Read data pending
	logic [31:0] rdata_r;     // Read data
	logic [1:0]  rresp_r;     // Read response code

	// Registers
	logic [15:0] ctrl_r;      // Control
	logic [7:0]  alert_r;     // Alert configuration
	logic [5:0]  bal_r;       // Balance outputs wanted
	logic [4:0]  cbt_r [6];   // Balance on-time limits
	logic [4:0]  pdt_r;       // Shutdown delay in minutes
	logic [4:0]  pd_cnt_r;    // Minutes left before power-down
	logic        pd_hw_r;     // Pending request came from the pin
	cbt_state_e  state_r;     // Power state
	cbt_state_e  state_nxt;   // Next power state

	// Pin synchroniser and edge history
	logic        pin_s1_r;    // First stage, read by second only
	logic        pin_s2_r;    // Second stage
	logic        pin_d_r;     // Previous synchronised level

	// Minute divider
	logic [32:0] div_r;       // Cycle count within a minute
	logic        tick;        // One-minute enable pulse

	// Write decode
	logic        wr_go;       // Both halves held, perform write
	logic        wr_ctrl;
	logic        wr_alert;
	logic        wr_bal;
	logic        wr_cbt;
	logic        wr_pdt;
	logic [7:0]  cbt_off;     // Offset into timer block
	logic [2:0]  cbt_idx;     // Balance timer addressed
	logic        wr_hit;      // Write address is mapped
	logic [15:0] wr_val;      // Write data merged by lanes
	logic [15:0] ctrl_new;    // Control after this write
	logic [4:0]  cbt_new;     // Clamped timer limit

	// Read decode
	logic        rd_cbt;
	logic [2:0]  rd_idx;
	logic        rd_hit;
	logic [31:0] rd_mux;
	logic [31:0] stat_w;      // Status word

	// Power control
	logic        hw_req;      // Pin fell
	logic        sw_req;      // Bit 8 newly set
	logic        pd_enter;    // Power-down takes effect now
	logic [5:0]  bal_start;   // Output just switched on
	logic [5:0]  bal_exp;     // Output on-time elapsed
	logic [4:0]  bal_rem [6]; // Minutes left per output

	// Bus handshakes
	assign awready = !aw_hold_r;
	assign wready  = !w_hold_r;
	assign arready = !rvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
	assign wr_go   = aw_hold_r && w_hold_r && !bvalid_r;

	// Address capture for writes, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (awvalid && awready) begin
			aw_hold_r <= 1'b1;
			aw_addr_r <= awaddr;
		end else if (wr_go) begin
			aw_hold_r <= 1'b0;
		end
	end

	// Data capture for writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (wvalid && wready) begin
			w_hold_r <= 1'b1;
			w_data_r <= wdata;
			w_strb_r <= wstrb;
		end else if (wr_go) begin
			w_hold_r <= 1'b0;
		end
	end

	// Write response after both halves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `CBT_RESP_OK;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? `CBT_RESP_OK : `CBT_RESP_ERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Write address decode
	assign wr_ctrl  = wr_go && aw_addr_r == `CBT_ADDR_CTRL;
	assign wr_alert = wr_go && aw_addr_r == `CBT_ADDR_ALERT;
	assign wr_bal   = wr_go && aw_addr_r == `CBT_ADDR_BAL;
	assign wr_pdt   = wr_go && aw_addr_r == `CBT_ADDR_PDT;
	assign cbt_off  = aw_addr_r - `CBT_ADDR_CBT0;
	assign cbt_idx  = cbt_off[4:2];
	assign wr_cbt   = wr_go && aw_addr_r >= `CBT_ADDR_CBT0
		&& aw_addr_r <= `CBT_ADDR_CBT5 && aw_addr_r[1:0] == 2'h0;
	assign wr_hit   = wr_ctrl || wr_alert || wr_bal || wr_pdt || wr_cbt
		|| aw_addr_r == `CBT_ADDR_STAT;

	// Lanes 0 and 1 carry every register
	assign wr_val = {w_strb_r[1] ? w_data_r[15:8] : ctrl_r[15:8],
		w_strb_r[0] ? w_data_r[7:0] : 8'h00};
	assign ctrl_new = wr_val & `CBT_CTRL_MASK;
	assign cbt_new  = wr_val[4:0] > `CBT_CBT_MAX ? `CBT_CBT_MAX
		: wr_val[4:0];

	// Control and alert configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r  <= `CBT_CTRL_RST;
			alert_r <= `CBT_ALERT_RST;
		end else begin
			if (wr_ctrl && w_strb_r[0])
				ctrl_r <= ctrl_new;
			else if (wr_ctrl)
				ctrl_r <= {ctrl_new[15:8], ctrl_r[7:0]};
			if (wr_alert && w_strb_r[0])
				alert_r <= wr_val[7:0];
		end
	end

	// Shutdown delay register, zero after reset
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pdt_r <= `CBT_TMR_RST;
		else if (wr_pdt && w_strb_r[0])
			pdt_r <= wr_val[4:0];
	end

	// Balance on-time limits, zero after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 6; i++)
				cbt_r[i] <= `CBT_TMR_RST;
		end else if (wr_cbt && w_strb_r[0]) begin
			cbt_r[cbt_idx] <= cbt_new;
		end
	end

	// Balance outputs: writes win over expiry; power-down clears
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bal_r <= `CBT_BAL_RST;
		else if (pd_enter)
			bal_r <= `CBT_BAL_RST;
		else if (wr_bal && w_strb_r[0])
			bal_r <= wr_val[5:0];
		else
			bal_r <= bal_r & ~bal_exp;
	end

	// One on-time counter per balance output
	assign bal_start = {6{wr_bal && w_strb_r[0] && !pd_enter}}
		& wr_val[5:0] & ~bal_r;
	for (genvar g = 0; g < 6; g++) begin : g_bal
		cbt_bal_timer u_tmr (
			.aclk    (aclk),
			.aresetn (aresetn),
			.start   (bal_start[g]),
			.limit   (cbt_r[g]),
			.tick    (tick),
			.expire  (bal_exp[g]),
			.remain  (bal_rem[g])
		);
	end

	// Balance outputs held off in either power-down state
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cell_balance_output <= `CBT_BAL_RST;
		else if (state_nxt == CBT_HWPD || state_nxt == CBT_SWPD)
			cell_balance_output <= `CBT_BAL_RST;
		else
			cell_balance_output <= pd_enter ? `CBT_BAL_RST
				: (wr_bal && w_strb_r[0] ? wr_val[5:0]
				: bal_r & ~bal_exp);
	end

	// Minute divider
	assign tick = div_r == MIN_CYC - 33'h1;
	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			div_r <= 33'h0;
		else
			div_r <= div_r + 33'h1;
	end

	// Pin synchroniser and falling-edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			pin_d_r  <= 1'b1;
		end else begin
			pin_s1_r <= shutdown_n_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end

	// Power-down requests
	assign hw_req = pin_d_r && !pin_s2_r;
	assign sw_req = wr_ctrl && w_strb_r[1]
		&& ctrl_new[`CBT_SWPD_BIT] && !ctrl_r[`CBT_SWPD_BIT];

	// Next power state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CBT_RUN: begin
				if ((hw_req || sw_req) && pdt_r == `CBT_TMR_RST)
					state_nxt = hw_req ? CBT_HWPD : CBT_SWPD;
				else if (hw_req || sw_req)
					state_nxt = CBT_WAIT;
			end
			CBT_WAIT: begin
				if (tick && pd_cnt_r == 5'h01)
					state_nxt = pd_hw_r ? CBT_HWPD : CBT_SWPD;
			end
			CBT_HWPD: begin
				if (pin_s2_r)
					state_nxt = CBT_RUN;
			end
			CBT_SWPD: begin
				if (hw_req)
					state_nxt = CBT_HWPD;
				else if (!ctrl_r[`CBT_SWPD_BIT])
					state_nxt = CBT_RUN;
			end
			default: state_nxt = CBT_RUN;
		endcase
	end

	assign pd_enter = (state_r == CBT_RUN || state_r == CBT_WAIT)
		&& (state_nxt == CBT_HWPD || state_nxt == CBT_SWPD);

	// Power state and delay countdown
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r  <= CBT_RUN;
			pd_cnt_r <= `CBT_TMR_RST;
			pd_hw_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == CBT_RUN && state_nxt == CBT_WAIT) begin
				pd_cnt_r <= pdt_r;
				pd_hw_r  <= hw_req;
			end else if (state_r == CBT_WAIT && tick) begin
				pd_cnt_r <= pd_cnt_r - 5'h01;
			end
		end
	end

	// Power outputs
	assign full_pd       = state_r == CBT_HWPD;
	assign soft_pd       = state_r == CBT_SWPD;
	assign core_power_en = !full_pd && !soft_pd;
	assign link_power_en = !full_pd;

	// Conversion configuration
	assign cfg.conv_sel     = ctrl_r[`CBT_CONV_HI:`CBT_CONV_LO];
	assign cfg.readback_sel = ctrl_r[`CBT_RDB_HI:`CBT_RDB_LO];
	assign cfg.avg_sel      = ctrl_r[`CBT_AVG_HI:`CBT_AVG_LO];
	assign cfg.acq_sel      = ctrl_r[`CBT_ACQ_HI:`CBT_ACQ_LO];
	assign cfg.term_en      = ctrl_r[`CBT_TERM_BIT];
	assign temp_conv_en = cfg.conv_sel == 2'h0 ? `CBT_TEMP_ALL
		: cfg.conv_sel == 2'h1 ? `CBT_TEMP_ODD : `CBT_TEMP_NONE;
	assign self_test_mode = cfg.conv_sel == 2'h3;
	assign acq_cycles = ACQ_STEP * (8'(cfg.acq_sel) + 8'h01);

	// Temperature channels kept in fault detection
	assign temp_fault_en =
		alert_r[`CBT_TEXC_HI:`CBT_TEXC_LO] == 2'h1 ? `CBT_TFLT_NO5
		: alert_r[`CBT_TEXC_HI:`CBT_TEXC_LO] == 2'h2 ? `CBT_TFLT_NO53
		: `CBT_TEMP_ALL;

	// Status word
	assign stat_w = {10'h000, pd_cnt_r, bal_r, cell_balance_output,
		1'b0, state_r};

	// Read decode
	assign rd_cbt = araddr >= `CBT_ADDR_CBT0
		&& araddr <= `CBT_ADDR_CBT5 && araddr[1:0] == 2'h0;
	assign rd_idx = 3'((araddr - `CBT_ADDR_CBT0) >> 2);
	assign rd_hit = rd_cbt || araddr == `CBT_ADDR_CTRL
		|| araddr == `CBT_ADDR_ALERT || araddr == `CBT_ADDR_BAL
		|| araddr == `CBT_ADDR_PDT || araddr == `CBT_ADDR_STAT;
	assign rd_mux =
		araddr == `CBT_ADDR_CTRL  ? {16'h0000, ctrl_r}
		: araddr == `CBT_ADDR_ALERT ? {24'h000000, alert_r}
		: araddr == `CBT_ADDR_BAL   ? {26'h0000000, bal_r}
		: araddr == `CBT_ADDR_PDT   ? {27'h0000000, pdt_r}
		: araddr == `CBT_ADDR_STAT  ? stat_w
		: rd_cbt ? {19'h00000, bal_rem[rd_idx], 3'h0, cbt_r[rd_idx]}
		: 32'h0000_0000;

	// Read data one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `CBT_RESP_OK;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_hit ? `CBT_RESP_OK : `CBT_RESP_ERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule

/* test/cbt_top_props.sv */
`timescale 1ns/100ps
// Port checks for the balance and shutdown block
module cbt_props
	import cbt_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire cbt_pkg::cbt_cfg_s cfg,
	input wire logic [5:0]        temp_conv_en,
	input wire logic              self_test_mode,
	input wire logic [7:0]        acq_cycles,
	input wire logic [5:0]        cell_balance_output,
	input wire logic              full_pd,
	input wire logic              soft_pd,
	input wire logic              core_power_en,
	input wire logic              link_power_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Expected temperature conversion set
	function automatic logic [5:0] conv_map(logic [1:0] s);
		return s == 2'h0 ? 6'h3F : (s == 2'h1 ? 6'h15 : 6'h00);
	endfunction
	// Handshake completions
	sequence s_b_hs; bvalid && bready; endsequence
	sequence s_r_hs; rvalid && rready; endsequence
	property p_conv; temp_conv_en == conv_map(cfg.conv_sel); endproperty
	property p_self; self_test_mode == (cfg.conv_sel == 2'h3); endproperty
	property p_acq;
		acq_cycles == 8'h28 * ({6'h00, cfg.acq_sel} + 8'h01);
	endproperty
	property p_pd_off;
		$rose(full_pd) || $rose(soft_pd) |-> cell_balance_output == 6'h00;
	endproperty
	property p_core; core_power_en == !(full_pd || soft_pd); endproperty
	property p_link; link_power_en == !full_pd; endproperty
	property p_bdone; s_b_hs |=> !bvalid; endproperty
	property p_rdone; s_r_hs |=> !rvalid; endproperty
	a_conv: assert property (p_conv)
		else $error("conversion enable mismatch");
	a_self: assert property (p_self)
		else $error("self test mode mismatch");
	a_acq: assert property (p_acq)
		else $error("acquisition cycles mismatch");
	a_pd_off: assert property (p_pd_off)
		else $error("balance outputs on at power-down");
	a_core: assert property (p_core)
		else $error("core power enable mismatch");
	a_link: assert property (p_link)
		else $error("link power enable mismatch");
	a_bdone: assert property (p_bdone)
		else $error("write response not retired");
	a_rdone: assert property (p_rdone)
		else $error("read data not retired");
endmodule

/* test/cbt_host.sv */
`timescale 1ns/100ps
// Host model: register bus master and shutdown pin
module cbt_host (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid,
	output logic             rready,
	output logic             shutdown_n_pin
);
	// Idle bus, pin high
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		shutdown_n_pin = 1'b1;
	end
	// One write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	// One read
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask
	// Shutdown pin level
	task automatic pin(input logic v);
		@(posedge aclk);
		shutdown_n_pin <= v;
	endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	import cbt_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic        shutdown_n_pin, self_test_mode, full_pd, soft_pd;
	logic        core_power_en, link_power_en;
	logic [7:0]  awaddr, araddr, acq_cycles;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [5:0]  cell_balance_output, temp_conv_en, temp_fault_en;
	cbt_cfg_s    cfg;
	int          error_cnt, n_compared;
	// Minute shortened to 20 cycles
	cbt_top #(.MIN_CYC(33'h14)) u_dut (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .shutdown_n_pin, .cell_balance_output, .cfg,
		.temp_conv_en, .temp_fault_en, .self_test_mode, .acq_cycles,
		.full_pd, .soft_pd, .core_power_en, .link_power_en);
	cbt_host u_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rvalid, .rready, .shutdown_n_pin);
	// Compare and count
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Verdict
	task automatic end_of_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Power-up values
	task automatic t_reset;
		for (int a = 0; a <= 36; a += 4) begin
			u_host.rd(8'(a), rv);
			if (a != 4) chk("reset reg", rv, 32'h0);
		end
		chk("bal out", cell_balance_output, 6'h00);
	endtask
	// Conversion, readback, acquisition and exclusion fields
	task automatic t_config;
		logic [5:0] cv[4] = '{6'h3F, 6'h15, 6'h00, 6'h00};
		logic [5:0] fe[3] = '{6'h3F, 6'h2F, 6'h2B};
		for (int i = 0; i < 4; i++) begin
			// Termination only with the longest acquisition
			u_host.wr(8'h00, 32'(i) << 14 | 32'(i) << 12 | 32'(i) << 5
				| (i == 3 ? 32'h8 : 32'h0), resp);
			#1;
			chk("conv", temp_conv_en, cv[i]);
			chk("self", self_test_mode, i == 3);
			chk("rdback", cfg.readback_sel, i);
			chk("acq", acq_cycles, 40 * (i + 1));
			chk("term", cfg.term_en, i == 3);
		end
		for (int i = 0; i < 3; i++) begin
			u_host.wr(8'h04, i, resp);
			#1;
			chk("fault", temp_fault_en, fe[i]);
		end
		u_host.wr(8'h00, 32'h0, resp);
		u_host.wr(8'h40, 32'h0, resp);
		chk("bresp", resp, 2'h2);
		u_host.rd(8'h40, rv);
		chk("rresp", rresp, 2'h2);
	endtask
	// Balance outputs with timed and unlimited channels
	task automatic t_bal;
		u_host.wr(8'h14, 32'h1F, resp);
		u_host.rd(8'h14, rv);
		chk("limit", rv[4:0], 5'h1E);
		u_host.wr(8'h0C, 32'h2, resp);
		u_host.wr(8'h10, 32'h0, resp);
		u_host.wr(8'h08, 32'h3, resp);
		#1;
		chk("bal on", cell_balance_output, 6'h03);
		repeat (15) @(posedge aclk);
		#1;
		chk("bal hold", cell_balance_output, 6'h03);
		repeat (30) @(posedge aclk);
		#1;
		chk("bal end", cell_balance_output, 6'h02);
	endtask
	// Software power-down with zero delay
	task automatic t_swpd;
		u_host.wr(8'h08, 32'h3F, resp);
		u_host.wr(8'h00, 32'h100, resp);
		#1;
		chk("soft pd", soft_pd, 1'b1);
		chk("bal off", cell_balance_output, 6'h00);
		chk("link on", link_power_en, 1'b1);
		u_host.wr(8'h00, 32'h0, resp);
		repeat (2) @(posedge aclk);
		#1;
		chk("wake", soft_pd, 1'b0);
	endtask
	// Pin power-down after a two minute delay
	task automatic t_hwpd;
		u_host.wr(8'h24, 32'h2, resp);
		u_host.wr(8'h08, 32'h20, resp);
		u_host.pin(1'b0);
		repeat (15) @(posedge aclk);
		#1;
		chk("delay", full_pd, 1'b0);
		chk("bal keep", cell_balance_output, 6'h20);
		u_host.rd(8'h28, rv);
		chk("wait state", rv[3:0], 4'h2);
		repeat (35) @(posedge aclk);
		#1;
		chk("full pd", full_pd, 1'b1);
		chk("bal cut", cell_balance_output, 6'h00);
		u_host.pin(1'b1);
		repeat (6) @(posedge aclk);
		#1;
		chk("up", full_pd, 1'b0);
		chk("core on", core_power_en, 1'b1);
		// Idle pause of one minute, 20 cycles, before the verdict
		repeat (20) @(posedge aclk);
	endtask
	// Clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Watchdog
	initial begin
		#200us;
		error_cnt++;
		end_of_test();
	end
	// Main sequence
	initial begin
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_config();
		t_bal();
		t_swpd();
		t_hwpd();
		end_of_test();
	end
endmodule
bind cbt_top cbt_props u_props (.aclk, .aresetn, .bvalid, .bready,
	.rvalid, .rready, .cfg, .temp_conv_en, .self_test_mode,
	.acq_cycles, .cell_balance_output, .full_pd, .soft_pd,
	.core_power_en, .link_power_en);
